/* File: src/ptt_defs.svh */
`ifndef PTT_DEFS_SVH
`define PTT_DEFS_SVH
`define FRAME_LEN 10'd537
`define POS_FA1 10'd0
`define POS_FA2 10'd1
`define POS_EM 10'd2
`define POS_TR 10'd3
`define POS_MA 10'd4
`define POS_NR 10'd5
`define FA1_VAL 8'hf6
`define FA2_VAL 8'h28
`define NR_FILL 8'h00
`define AIS_BYTE 8'hff
`define MA_RDI 7
`define MA_REI 6
`define MA_LBL 5:3
`define LBL_UNEQ 3'h0
`define PERSIST 3'h5
`define TRACE_HITS 2'h2
`define TRACE_MARK 7
`define TRACE_LAST 5'h0f
`define TRACE_DONE 5'h10
`define CTRL_MON 0
`define CTRL_SSFREP 1
`define CTRL_RDIREP 2
`define CTRL_MISMATCH_DETECT_DISABLE 3
`define DEG_THR 15:0
`define DEG_WIN 23:16
`define DEG_CFG_RST 32'h00030010
`define REG_CTRL 8'h00
`define REG_DEG 8'h04
`define REG_STATUS 8'h08
`define REG_PERF 8'h0c
`define BANK_SENT 4'h1
`define BANK_EXP 4'h2
`define BANK_ACC 4'h3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define PARITY_VIOLATION_MAX 4'h8
`define CLK_NS 100
`define ACT_MAX_US 250
`define ACT_MAX_CYC (`ACT_MAX_US * 1000 / `CLK_NS)
`endif

/* File: src/ptt_pkg.sv */
package ptt_pkg;
	typedef logic [7:0] byte_t;
	typedef struct packed {
		logic [2:0] ck;
		logic [9:0] pos;
		byte_t bip;
		byte_t em;
		logic [3:0] tr_idx;
		byte_t data;
		logic fs;
		logic take;
		logic ma_now;
	} src_s;
	typedef struct packed {
		logic [127:0] buffer;
		logic [4:0] idx;
		logic [127:0] cand;
		logic [1:0] hits;
		logic [127:0] acc;
		logic valid;
	} acc_s;
	typedef struct packed {
		logic [2:0] rck;
		byte_t d1;
		byte_t d2;
		logic [1:0] fsy;
		logic [9:0] pos;
		logic seen;
		logic have_prev;
		byte_t bip;
		byte_t bip_prev;
		logic [3:0] rem_err;
		logic [2:0] rdi_cnt;
		logic rdi_d;
		logic [2:0] uneq_cnt;
		logic uneq_d;
		logic [15:0] nebc;
		logic [15:0] febc;
		logic nds;
		logic fds;
		logic [15:0] perf_n;
		logic [15:0] perf_f;
		logic near_defect_second;
		logic far_defect_second;
		logic [7:0] deg_cnt;
		logic deg_d;
		byte_t ai_data;
		logic ai_fs;
		logic ai_stb;
		logic tsf;
		logic tsd;
		logic trace_stb;
		byte_t trace_byte;
		logic aw_have;
		logic [7:0] aw_addr;
		logic w_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [3:0] ctrl;
		logic [31:0] deg_cfg;
		logic [127:0] sent;
		logic [127:0] expect_tr;
	} sink_s;
endpackage : ptt_pkg

/* File: src/trail_source.sv */
`timescale 1ns/1ps
`include "ptt_defs.svh"
module trail_source (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic tx_link_clk,
	input wire logic [127:0] sent_path_trace,
	input wire logic remote_defect_request,
	input wire logic [3:0] remote_error_request,
	input wire logic [5:0] label_in,
	input wire logic [7:0] payload_in,
	output logic payload_take,
	output logic [7:0] tx_data,
	output logic tx_frame_start
);
	ptt_pkg::src_s state_ff;
	ptt_pkg::src_s nxt_state;
	logic edge_seen;

	assign edge_seen = state_ff.ck[1] & ~state_ff.ck[2];
	assign tx_data = state_ff.data;
	assign tx_frame_start = state_ff.fs;
	assign payload_take = state_ff.take;

	always_comb begin
		ptt_pkg::byte_t b;
		b = `NR_FILL;
		nxt_state = state_ff;
		nxt_state.ck = {state_ff.ck[1:0], tx_link_clk};
		nxt_state.take = 1'b0;
		nxt_state.ma_now = 1'b0;
		if (edge_seen) begin
			case (state_ff.pos)
			`POS_FA1: b = `FA1_VAL;
			`POS_FA2: b = `FA2_VAL;
			`POS_EM: b = state_ff.em;
			`POS_TR: b = sent_path_trace[{state_ff.tr_idx, 3'h0} +: 8];
			`POS_MA: begin
				// Requests sampled once per frame, well inside 250 us
				b = {remote_defect_request, |remote_error_request,
					label_in};
				nxt_state.ma_now = 1'b1;
			end
			`POS_NR: b = `NR_FILL;
			default: begin
				b = payload_in;
				nxt_state.take = 1'b1;
			end
			endcase
			nxt_state.data = b;
			nxt_state.fs = (state_ff.pos == `POS_FA1);
			if (state_ff.pos == `FRAME_LEN - 10'd1) begin
				nxt_state.pos = `POS_FA1;
				nxt_state.em = state_ff.bip ^ b;
				nxt_state.bip = 8'h00;
				nxt_state.tr_idx = state_ff.tr_idx + 4'h1;
			end else begin
				nxt_state.pos = state_ff.pos + 10'd1;
				nxt_state.bip = state_ff.bip ^ b;
			end
		end
		if (!aresetn) begin
			nxt_state = '0;
		end
	end

	always_ff @(posedge aclk) begin
		state_ff <= nxt_state;
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_frame_word: assert property (state_ff.fs |->
		state_ff.data == `FA1_VAL)
		else $error("frame start byte is not the alignment word");
	a_rdi_bit: assert property (state_ff.ma_now |->
		state_ff.data[`MA_RDI] == $past(remote_defect_request))
		else $error("remote defect bit does not follow request");
	a_rei_bit: assert property (state_ff.ma_now |->
		state_ff.data[`MA_REI] == ($past(remote_error_request) != 4'h0))
		else $error("remote error bit does not follow parity result");
endmodule : trail_source

/* File: src/trace_acceptor.sv */
`timescale 1ns/1ps
`include "ptt_defs.svh"
module trace_acceptor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic trace_stb,
	input wire logic [7:0] trace_byte,
	output logic [127:0] accepted_path_trace,
	output logic accepted_valid
);
	ptt_pkg::acc_s state_ff;
	ptt_pkg::acc_s nxt_state;

	assign accepted_path_trace = state_ff.acc;
	assign accepted_valid = state_ff.valid;

	always_comb begin
		logic [127:0] full;
		full = {trace_byte, state_ff.buffer[119:0]};
		nxt_state = state_ff;
		if (trace_stb) begin
			// Mode 1 only: the marked byte opens each 16-byte message
			if (trace_byte[`TRACE_MARK]) begin
				nxt_state.buffer[7:0] = trace_byte;
				nxt_state.idx = 5'h01;
			end else if (state_ff.idx == `TRACE_LAST) begin
				nxt_state.idx = `TRACE_DONE;
				if (full == state_ff.cand) begin
					if (state_ff.hits == `TRACE_HITS) begin
						nxt_state.acc = state_ff.cand;
						nxt_state.valid = 1'b1;
					end else begin
						nxt_state.hits = state_ff.hits + 2'h1;
					end
				end else begin
					nxt_state.cand = full;
					nxt_state.hits = 2'h0;
				end
			end else if (state_ff.idx != 5'h00 &&
				state_ff.idx != `TRACE_DONE) begin
				nxt_state.buffer[{state_ff.idx[3:0], 3'h0} +: 8] = trace_byte;
				nxt_state.idx = state_ff.idx + 5'h01;
			end
		end
		if (!aresetn) begin
			nxt_state = '0;
		end
	end

	always_ff @(posedge aclk) begin
		state_ff <= nxt_state;
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_trace_accept: assert property ($changed(state_ff.acc) |->
		$past(state_ff.hits) == `TRACE_HITS && state_ff.valid)
		else $error("trace accepted without enough matching messages");
endmodule : trace_acceptor

/* File: src/path_trail_termination_34m.sv */
// Summary of operation
// - Source sends configured trace byte each frame
// - Source mirrors remote defect request in bit 1
// - Source sets bit 2 on sink parity errors
// - Source parity byte covers whole previous frame
// - Source inserts alignment word every frame
// - Sink checks per-bit parity against next frame
// - Sink assembles and accepts 16-byte trace
// - Only first trace mode is supported
// - Sink extracts remote defect and error bits
// - Sink uses label bits to detect unequipped
// - All ones output on unequipped or mismatch
// - Trail fail, remote defect, degrade actions
// - Degrade and mismatch causes properly masked
// - Remote defect cause needs monitoring and enable
// - Server fail cause optional, default off
// - Remote defect cause optional, default off
// - Per-second error counts and defect seconds
// - Octet frame of 537 bytes, 125 us
// - Adapted payload bytes plus label bits
//
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "ptt_defs.svh"
module path_trail_termination_34m (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic rx_link_clk,
	input wire logic [7:0] rx_data,
	input wire logic rx_frame_start,
	input wire logic tx_link_clk,
	output logic [7:0] tx_data,
	output logic tx_frame_start,
	input wire logic [7:0] src_payload,
	input wire logic [5:0] src_label,
	output logic src_payload_take,
	input wire logic server_signal_fail_in,
	input wire logic equipment_defect,
	input wire logic one_second_tick,
	output logic [7:0] ai_data,
	output logic ai_frame_start,
	output logic ai_strobe,
	output logic trail_fail_action,
	output logic trail_degrade_action
);
	ptt_pkg::sink_s state_ff;
	ptt_pkg::sink_s nxt_state;
	logic [127:0] accepted_path_trace;
	logic accepted_valid;
	logic edge_seen;
	logic mon;
	logic trace_mismatch_defect;
	logic all_ones_insert_action;
	logic unequipped_fault_cause;
	logic mismatch_fault_cause;
	logic degraded_fault_cause;
	logic remote_defect_fault_cause;
	logic server_fail_fault_cause;
	logic [31:0] status_word;
	logic [11:0] ais_wait_ff;

	function automatic logic [3:0] ones8(input ptt_pkg::byte_t v);
		logic [3:0] c;
		c = 4'h0;
		for (int i = 0; i < 8; i++) begin
			c = c + {3'h0, v[i]};
		end
		return c;
	endfunction : ones8

	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] d, input logic [3:0] st);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[8 * i +: 8] = d[8 * i +: 8];
			end
		end
		return r;
	endfunction : merge

	// Returns {state, count}; a change needs five frames in a row
	function automatic logic [3:0] persist(input logic d, input logic obs,
		input logic [2:0] c);
		logic [3:0] r;
		r = {d, 3'h0};
		if (obs != d) begin
			if (c == `PERSIST - 3'h1) begin
				r = {obs, 3'h0};
			end else begin
				r = {d, c + 3'h1};
			end
		end
		return r;
	endfunction : persist

	////////////////////////////////////////////////////////////////////////
	// Source direction and trace recovery

	trail_source u_source (
		.aclk(aclk),
		.aresetn(aresetn),
		.tx_link_clk(tx_link_clk),
		.sent_path_trace(state_ff.sent),
		.remote_defect_request(state_ff.tsf),
		.remote_error_request(state_ff.rem_err),
		.label_in(src_label),
		.payload_in(src_payload),
		.payload_take(src_payload_take),
		.tx_data(tx_data),
		.tx_frame_start(tx_frame_start)
	);

	trace_acceptor u_trace (
		.aclk(aclk),
		.aresetn(aresetn),
		.trace_stb(state_ff.trace_stb),
		.trace_byte(state_ff.trace_byte),
		.accepted_path_trace(accepted_path_trace),
		.accepted_valid(accepted_valid)
	);

	////////////////////////////////////////////////////////////////////////
	// Defect correlation

	assign mon = state_ff.ctrl[`CTRL_MON];
	assign trace_mismatch_defect = accepted_valid &
		(accepted_path_trace != state_ff.expect_tr) &
		~state_ff.ctrl[`CTRL_MISMATCH_DETECT_DISABLE];
	assign all_ones_insert_action = state_ff.uneq_d |
		trace_mismatch_defect;
	assign unequipped_fault_cause = mon & state_ff.uneq_d;
	assign mismatch_fault_cause = mon & trace_mismatch_defect &
		~state_ff.uneq_d;
	assign degraded_fault_cause = mon & state_ff.deg_d & ~state_ff.uneq_d &
		~trace_mismatch_defect;
	assign remote_defect_fault_cause = mon & state_ff.rdi_d &
		~trace_mismatch_defect & ~state_ff.uneq_d &
		state_ff.ctrl[`CTRL_RDIREP];
	assign server_fail_fault_cause = mon & server_signal_fail_in &
		state_ff.ctrl[`CTRL_SSFREP];
	assign status_word = {18'h0, trace_mismatch_defect, state_ff.uneq_d,
		state_ff.rdi_d, accepted_valid, state_ff.far_defect_second, state_ff.near_defect_second,
		all_ones_insert_action, state_ff.tsd, state_ff.tsf,
		server_fail_fault_cause, remote_defect_fault_cause,
		degraded_fault_cause, mismatch_fault_cause,
		unequipped_fault_cause};

	assign edge_seen = state_ff.rck[1] & ~state_ff.rck[2];
	assign ai_data = state_ff.ai_data;
	assign ai_frame_start = state_ff.ai_fs;
	assign ai_strobe = state_ff.ai_stb;
	assign trail_fail_action = state_ff.tsf;
	assign trail_degrade_action = state_ff.tsd;
	assign s_axi_awready = ~state_ff.aw_have & ~state_ff.bvalid;
	assign s_axi_wready = ~state_ff.w_have & ~state_ff.bvalid;
	assign s_axi_arready = ~state_ff.rvalid;
	assign s_axi_bvalid = state_ff.bvalid;
	assign s_axi_bresp = state_ff.bresp;
	assign s_axi_rvalid = state_ff.rvalid;
	assign s_axi_rdata = state_ff.rdata;
	assign s_axi_rresp = state_ff.rresp;

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		ptt_pkg::byte_t rb;
		logic [9:0] p;
		logic [3:0] parity_violation;
		logic [3:0] pr;
		logic ne_inc;
		logic fe_inc;
		logic [15:0] nb;
		logic [15:0] fb;
		logic [7:0] dc;
		logic [1:0] w;
		logic [31:0] mw;
		rb = state_ff.d2;
		p = state_ff.pos + 10'd1;
		parity_violation = 4'h0;
		pr = 4'h0;
		ne_inc = 1'b0;
		fe_inc = 1'b0;
		dc = state_ff.deg_cnt + 8'h01;
		w = state_ff.aw_addr[3:2];
		mw = 32'h0;
		nxt_state = state_ff;
		// Link pins pass two flops before the edge finder reads them
		nxt_state.rck = {state_ff.rck[1:0], rx_link_clk};
		nxt_state.d1 = rx_data;
		nxt_state.d2 = state_ff.d1;
		nxt_state.fsy = {state_ff.fsy[0], rx_frame_start};
		nxt_state.ai_stb = 1'b0;
		nxt_state.trace_stb = 1'b0;
		if (edge_seen) begin
			if (state_ff.fsy[1]) begin
				p = `POS_FA1;
				nxt_state.seen = 1'b1;
				nxt_state.have_prev = state_ff.seen;
				nxt_state.bip_prev = state_ff.bip;
				nxt_state.bip = rb;
			end else begin
				if (state_ff.pos == `FRAME_LEN - 10'd1) begin
					p = state_ff.pos;
				end
				nxt_state.bip = state_ff.bip ^ rb;
			end
			nxt_state.pos = p;
			if (p == `POS_EM && state_ff.have_prev) begin
				parity_violation = ones8(rb ^ state_ff.bip_prev);
				nxt_state.rem_err = parity_violation;
				ne_inc = (parity_violation != 4'h0);
			end
			if (p == `POS_TR) begin
				nxt_state.trace_stb = 1'b1;
				nxt_state.trace_byte = rb;
			end
			if (p == `POS_MA) begin
				fe_inc = rb[`MA_REI];
				pr = persist(state_ff.rdi_d, rb[`MA_RDI],
					state_ff.rdi_cnt);
				nxt_state.rdi_d = pr[3];
				nxt_state.rdi_cnt = pr[2:0];
				pr = persist(state_ff.uneq_d,
					rb[`MA_LBL] == `LBL_UNEQ,
					state_ff.uneq_cnt);
				nxt_state.uneq_d = pr[3];
				nxt_state.uneq_cnt = pr[2:0];
			end
			nxt_state.ai_data = all_ones_insert_action ? `AIS_BYTE : rb;
			nxt_state.ai_fs = state_ff.fsy[1];
			nxt_state.ai_stb = 1'b1;
		end

		// Consequent actions; remote_defect_action equals trail_fail_action so the flop is shared
		nxt_state.tsf = server_signal_fail_in | state_ff.uneq_d |
			trace_mismatch_defect;
		nxt_state.tsd = state_ff.deg_d;

		// One-second accumulation; counts wrap at 16 bits
		nb = state_ff.nebc + {15'h0, ne_inc};
		fb = state_ff.febc + {15'h0, fe_inc};
		nxt_state.nebc = nb;
		nxt_state.febc = fb;
		nxt_state.nds = state_ff.nds | state_ff.tsf | equipment_defect;
		nxt_state.fds = state_ff.fds | state_ff.rdi_d;
		if (one_second_tick) begin
			nxt_state.perf_n = nb;
			nxt_state.perf_f = fb;
			nxt_state.near_defect_second = nxt_state.nds;
			nxt_state.far_defect_second = nxt_state.fds;
			nxt_state.nebc = 16'h0;
			nxt_state.febc = 16'h0;
			nxt_state.nds = 1'b0;
			nxt_state.fds = 1'b0;
			nxt_state.deg_cnt = 8'h00;
			if ((nb >= state_ff.deg_cfg[`DEG_THR]) != state_ff.deg_d) begin
				nxt_state.deg_cnt = dc;
				if (dc >= state_ff.deg_cfg[`DEG_WIN]) begin
					nxt_state.deg_d = ~state_ff.deg_d;
					nxt_state.deg_cnt = 8'h00;
				end
			end
		end

		// Register bus: address and data taken in either order
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_state.aw_have = 1'b1;
			nxt_state.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_state.w_have = 1'b1;
			nxt_state.w_data = s_axi_wdata;
			nxt_state.w_strb = s_axi_wstrb;
		end
		if (state_ff.aw_have && state_ff.w_have) begin
			nxt_state.aw_have = 1'b0;
			nxt_state.w_have = 1'b0;
			nxt_state.bvalid = 1'b1;
			nxt_state.bresp = `RESP_OKAY;
			case (state_ff.aw_addr[7:4])
			4'h0: begin
				if (state_ff.aw_addr == `REG_CTRL) begin
					mw = merge({28'h0, state_ff.ctrl},
						state_ff.w_data, state_ff.w_strb);
					nxt_state.ctrl = mw[3:0];
				end else if (state_ff.aw_addr == `REG_DEG) begin
					nxt_state.deg_cfg = merge(state_ff.deg_cfg,
						state_ff.w_data, state_ff.w_strb);
				end else begin
					nxt_state.bresp = `RESP_SLVERR;
				end
			end
			`BANK_SENT: nxt_state.sent[{w, 5'h0} +: 32] = merge(
				state_ff.sent[{w, 5'h0} +: 32], state_ff.w_data,
				state_ff.w_strb);
			`BANK_EXP: nxt_state.expect_tr[{w, 5'h0} +: 32] = merge(
				state_ff.expect_tr[{w, 5'h0} +: 32], state_ff.w_data,
				state_ff.w_strb);
			default: nxt_state.bresp = `RESP_SLVERR;
			endcase
		end
		if (state_ff.bvalid && s_axi_bready) begin
			nxt_state.bvalid = 1'b0;
		end
		if (state_ff.rvalid && s_axi_rready) begin
			nxt_state.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			nxt_state.rvalid = 1'b1;
			nxt_state.rresp = `RESP_OKAY;
			nxt_state.rdata = 32'h0;
			case (s_axi_araddr[7:4])
			4'h0: begin
				case (s_axi_araddr)
				`REG_CTRL: nxt_state.rdata = {28'h0, state_ff.ctrl};
				`REG_DEG: nxt_state.rdata = state_ff.deg_cfg;
				`REG_STATUS: nxt_state.rdata = status_word;
				`REG_PERF: nxt_state.rdata = {state_ff.perf_f,
					state_ff.perf_n};
				default: nxt_state.rresp = `RESP_SLVERR;
				endcase
			end
			`BANK_SENT: nxt_state.rdata =
				state_ff.sent[{s_axi_araddr[3:2], 5'h0} +: 32];
			`BANK_EXP: nxt_state.rdata =
				state_ff.expect_tr[{s_axi_araddr[3:2], 5'h0} +: 32];
			`BANK_ACC: nxt_state.rdata =
				accepted_path_trace[{s_axi_araddr[3:2], 5'h0} +: 32];
			default: nxt_state.rresp = `RESP_SLVERR;
			endcase
		end

		// Reporting options come up disabled
		if (!aresetn) begin
			nxt_state = '0;
			nxt_state.deg_cfg = `DEG_CFG_RST;
		end
	end

	always_ff @(posedge aclk) begin
		state_ff <= nxt_state;
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	always_ff @(posedge aclk) begin
		if (!aresetn || !all_ones_insert_action ||
			state_ff.ai_data == `AIS_BYTE) begin
			ais_wait_ff <= 12'h000;
		end else begin
			ais_wait_ff <= ais_wait_ff + 12'h001;
		end
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_ais_latency: assert property (ais_wait_ff < 12'(`ACT_MAX_CYC))
		else $error("all ones output late");
	a_trail_fail: assert property ((server_signal_fail_in ||
		state_ff.uneq_d) |=> trail_fail_action)
		else $error("trail fail not raised");
	a_deg_mask: assert property (degraded_fault_cause |->
		state_ff.deg_d && !state_ff.uneq_d && !trace_mismatch_defect)
		else $error("degrade cause not masked");
	a_rdi_mask: assert property (remote_defect_fault_cause |->
		state_ff.rdi_d && state_ff.ctrl[`CTRL_RDIREP] && mon)
		else $error("remote defect cause reported while off");
	a_ssf_option: assert property (!state_ff.ctrl[`CTRL_SSFREP] |->
		!server_fail_fault_cause)
		else $error("server fail cause reported while off");
	a_rem_err: assert property (state_ff.rem_err <= `PARITY_VIOLATION_MAX)
		else $error("remote error count above eight");
	a_ais_data: assert property ((edge_seen &&
		all_ones_insert_action) |=> ai_strobe && ai_data == `AIS_BYTE)
		else $error("data passed during all ones insertion");
endmodule : path_trail_termination_34m

/* File: verification/far_side_model.sv */
`timescale 1ns/1ps
module far_side_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic src_payload_take,
	output logic [7:0] src_payload,
	output logic rx_link_clk,
	output logic [7:0] rx_data,
	output logic rx_frame_start,
	input wire logic [2:0] rx_label,
	input wire logic rx_rdi,
	input wire logic rx_err
);
	logic [9:0] pos;
	logic [7:0] acc, prv, b;
	////////////////////////////////////////////////////////////////////
	// Adaptation side: next payload byte after each take
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			src_payload <= 8'h00;
		end else if (src_payload_take) begin
			src_payload <= src_payload + 8'h01;
		end
	end
	////////////////////////////////////////////////////////////////////
	// Link clock runs free; data moves on the falling edge for margin
	initial begin
		rx_link_clk = 1'h0;
		rx_data = 8'h00;
		rx_frame_start = 1'h0;
		pos = 10'h218;
		acc = 8'h00;
		prv = 8'h00;
		#137;
		forever begin
			#400;
			rx_link_clk = ~rx_link_clk;
			if (!rx_link_clk) begin
				pos = (pos == 10'h218) ? 10'h000 : pos + 10'h001;
				if (pos == 10'h000) begin
					prv = acc;
					acc = 8'h00;
				end
				case (pos)
					10'h000: b = 8'hf6;
					10'h001: b = 8'h28;
					10'h002: b = prv ^ {7'h00, rx_err};
					10'h003: b = 8'h00;
					10'h004: b = {rx_rdi, rx_err, rx_label, 3'h0};
					default: b = {1'h0, pos[6:0]};
				endcase
				acc = acc ^ b;
				rx_data = b;
				rx_frame_start = (pos == 10'h000);
			end
		end
	end
endmodule : far_side_model

/* File: verification/path_trail_termination_34m_tb_top.sv */
`timescale 1ns/1ps
module path_trail_termination_34m_tb_top;
	typedef struct packed {
		logic wr;
		logic [7:0] a;
		logic [31:0] d;
		logic [31:0] e;
		logic [1:0] r;
	} row_s;
	logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0;
	logic s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
	logic s_axi_rready = 1'h0, server_signal_fail_in = 1'h0;
	logic equipment_defect = 1'h0, one_second_tick = 1'h0;
	logic rx_rdi = 1'h0, rx_err = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [5:0] src_label = 6'h18;
	logic [2:0] rx_label = 3'h3;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, rx_link_clk, rx_frame_start, tx_link_clk;
	logic tx_frame_start, src_payload_take, ai_frame_start, ai_strobe;
	logic trail_fail_action, trail_degrade_action;
	logic [7:0] rx_data, tx_data, src_payload, ai_data;
	logic [31:0] s_axi_rdata, rd;
	logic [1:0] s_axi_bresp, s_axi_rresp, rp;
	logic [9:0] tpos = 10'h0;
	logic [7:0] tacc, tprv, tx_trace, tx_ma;
	int err_count, samples_checked, nfr, rei_cnt;
	row_s rows [7] = '{
		'{1'h0, 8'h00, 32'h0, 32'h0, 2'h0},
		'{1'h0, 8'h04, 32'h0, 32'h00030010, 2'h0},
		'{1'h1, 8'h10, 32'h5a5a5a5a, 32'h5a5a5a5a, 2'h0},
		'{1'h1, 8'h14, 32'h5a5a5a5a, 32'h5a5a5a5a, 2'h0},
		'{1'h1, 8'h18, 32'h5a5a5a5a, 32'h5a5a5a5a, 2'h0},
		'{1'h1, 8'h1c, 32'h5a5a5a5a, 32'h5a5a5a5a, 2'h0},
		'{1'h0, 8'h40, 32'h0, 32'h0, 2'h2}};
	// Control, fail input, then trail fail and server fail cause
	logic [6:0] srow [4] = '{7'h0e, 7'h1f, 7'h3f, 7'h28};
	assign tx_link_clk = rx_link_clk;
	path_trail_termination_34m dut_u (.*);
	far_side_model far_u (.*);
	////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] e, s);
		samples_checked++;
		if (e !== s) begin
			err_count++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task complete_run();
		$display("Checks %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : complete_run
	// A clock edge separates calls so no strobe is driven twice at once
	task axw(input logic [7:0] a, input logic [31:0] d);
		logic tb;
		tb = 1'h0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!tb) begin
			@(posedge aclk);
			tb = s_axi_bvalid && s_axi_bready;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
		end
		s_axi_bready <= 1'h0;
	endtask : axw
	task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic tr;
		tr = 1'h0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		while (!tr) begin
			@(posedge aclk);
			tr = s_axi_rvalid && s_axi_rready;
			d = s_axi_rdata;
			r = s_axi_rresp;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
		end
		s_axi_rready <= 1'h0;
	endtask : axr
	task frames(input int n);
		repeat (n) @(posedge rx_frame_start);
		@(posedge aclk);
	endtask : frames
	task tick();
		one_second_tick <= 1'h1;
		@(posedge aclk);
		one_second_tick <= 1'h0;
	endtask : tick
	task stat(input logic [31:0] e, input logic [7:0] a, input logic r);
		do @(negedge aclk);
		while (!(ai_strobe === 1'h1 && ai_frame_start === 1'h1));
		chk("ai byte", 32'(a), 32'(ai_data));
		chk("tx rdi", 32'(r), 32'(tx_ma[7]));
		@(posedge aclk);
		axr(8'h08, rd, rp);
		chk("status", e, rd & 32'h1829);
	endtask : stat
	////////////////////////////////////////////////////////////////////
	// Transmit monitor: alignment, parity and overhead capture
	always @(posedge tx_link_clk) begin
		if (tx_frame_start) begin
			tprv = tacc;
			tacc = 8'h00;
			tpos = 10'h0;
			nfr++;
			chk("fa1", 32'hf6, 32'(tx_data));
		end else begin
			tpos = tpos + 10'h1;
		end
		if (nfr > 0 && tpos == 10'h1) chk("fa2", 32'h28, 32'(tx_data));
		if (nfr > 1 && tpos == 10'h2) chk("bip", 32'(tprv), 32'(tx_data));
		if (tpos == 10'h3) tx_trace = tx_data;
		if (tpos == 10'h4) begin
			tx_ma = tx_data;
			if (tx_data[6]) rei_cnt++;
		end
		tacc = tacc ^ tx_data;
	end
	initial begin
		forever #50 aclk = ~aclk;
	end
	initial begin
		repeat (98000) @(posedge aclk);
		err_count++;
		complete_run();
	end
	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		foreach (rows[i]) begin
			if (rows[i].wr) axw(rows[i].a, rows[i].d);
			axr(rows[i].a, rd, rp);
			chk("rdata", rows[i].e, rd);
			chk("rresp", 32'(rows[i].r), 32'(rp));
		end
		foreach (srow[i]) begin
			server_signal_fail_in <= srow[i][2];
			axw(8'h00, {28'h0, srow[i][6:3]});
			axr(8'h08, rd, rp);
			chk("causes", 32'(srow[i][1:0]), 32'(rd[5:4]));
			chk("fail", 32'(srow[i][1]), 32'(trail_fail_action));
		end
		rx_rdi <= 1'h1;
		rx_label <= 3'h0;
		frames(8);
		stat(32'h1821, 8'hff, 1'h1);
		rx_label <= 3'h3;
		frames(7);
		stat(32'h0808, 8'hf6, 1'h0);
		chk("trace", 32'h5a, 32'(tx_trace));
		rx_rdi <= 1'h0;
		chk("rei idle", 32'h0, rei_cnt);
		tick();
		frames(1);
		rx_err <= 1'h1;
		frames(2);
		rx_err <= 1'h0;
		frames(2);
		tick();
		axr(8'h0c, rd, rp);
		chk("perf", 32'h00020002, rd);
		axr(8'h08, rd, rp);
		chk("seconds", 32'h0200, rd & 32'h0300);
		chk("rei", 32'h1, 32'(rei_cnt inside {[1:4]}));
		chk("degrade", 32'h0, 32'(trail_degrade_action));
		complete_run();
	end
endmodule : path_trail_termination_34m_tb_top
